// [core/misc_ctrl_status_regs.sv]
`timescale 1ns/1ps
// Behaviour
// - Channel 2 destination B address is a seven-bit read-write field in bits 7:1, reset zero.
// - A link transaction whose address equals channel 2 source B is sent on with destination B.
// - Bits 6, 5, 4 of the pipeline Z status read 1 when pixel-valid, frame and line sync toggle.
// - Bits 1 and 0 report frame and line sync polarity, 0 active low and 1 active high.
// - Port control fields are written only while the unlock key holds the unlock value.
// - Any other key value blocks those writes, and the key resets to the unlock value.
// - Each two-bit edge rate code drives its pin, 00 fastest and 11 slowest.
// - Pin 0 edge rate is bits 1:0 of the first slew register, reset binary 10.
// - Pin 1 edge rate is bits 3:2 and pin 2 bits 5:4 of the first slew register.
// - Pin 3 edge rate is bits 3:2 of the second slew register, reset binary 11.
// - Pin 4 edge rate is bits 5:4 of the second slew register, other bits unused.
module misc_ctrl_status_regs (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic [15:0] CFG_ADDR,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_WDATA,
  output logic [7:0] CFG_RDATA,
  output logic CFG_RVALID,
  input wire logic LINE_SYNC_Z,
  input wire logic FRAME_SYNC_Z,
  input wire logic PIXEL_VALID_Z,
  input wire logic [6:0] CH2_TRANSLATE_MATCH_B,
  input wire logic [6:0] LINK_ADDR,
  input wire logic LINK_ADDR_VALID,
  output logic [6:0] REMOTE_ADDR,
  output logic REMOTE_ADDR_VALID,
  output logic LOCAL_CTRL_DISABLE,
  output logic PASSTHRU_ONE_ENABLE,
  output logic PASSTHRU_TWO_ENABLE,
  output logic [1:0] PIN0_EDGE_RATE,
  output logic [1:0] PIN1_EDGE_RATE,
  output logic [1:0] PIN2_EDGE_RATE,
  output logic [1:0] PIN3_EDGE_RATE,
  output logic [1:0] PIN4_EDGE_RATE
);
  logic rst_meta;
  logic rst_n;
  logic [6:0] ch2_translate_target_b;
  logic [7:0] write_key;
  logic unlocked;
  misc_regs_pkg::sync_status_s sync_st;
  misc_regs_pkg::port_ctrl_s port_ctrl;
  logic [7:0] next_rdata;
  logic wr_dest;
  logic wr_key;
  logic wr_ctrl;
  logic wr_slew_a;
  logic wr_slew_b;

  // ==========================================================
  // Reset release
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // Address decode
  assign wr_dest = CFG_WR && (CFG_ADDR == misc_regs_pkg::ADDR_DEST_B);
  assign wr_key = CFG_WR && (CFG_ADDR == misc_regs_pkg::ADDR_KEY);
  assign wr_ctrl = CFG_WR && (CFG_ADDR == misc_regs_pkg::ADDR_PORT_CTRL);
  assign wr_slew_a = CFG_WR && (CFG_ADDR == misc_regs_pkg::ADDR_SLEW_A);
  assign wr_slew_b = CFG_WR && (CFG_ADDR == misc_regs_pkg::ADDR_SLEW_B);
  assign unlocked = (write_key == misc_regs_pkg::UNLOCK_VALUE);

  // ==========================================================
  // Translator destination B
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ch2_translate_target_b <= misc_regs_pkg::RST_DEST_B;
    end else if (wr_dest) begin
      ch2_translate_target_b <= CFG_WDATA[misc_regs_pkg::DEST_B_LSB +: 7];
    end
  end

  // ==========================================================
  // Address substitution toward the remote side
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      REMOTE_ADDR <= 7'h00;
      REMOTE_ADDR_VALID <= 1'b0;
    end else begin
      REMOTE_ADDR_VALID <= LINK_ADDR_VALID;
      if (LINK_ADDR_VALID) begin
        if (LINK_ADDR == CH2_TRANSLATE_MATCH_B) begin
          REMOTE_ADDR <= ch2_translate_target_b;
        end else begin
          REMOTE_ADDR <= LINK_ADDR;
        end
      end
    end
  end

  // ==========================================================
  // Unlock key and gated port control
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      write_key <= misc_regs_pkg::RST_KEY;
    end else if (wr_key) begin
      write_key <= CFG_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      port_ctrl <= misc_regs_pkg::RST_PORT_CTRL;
    end else if (wr_ctrl && unlocked) begin
      port_ctrl.local_ctrl_disable <= CFG_WDATA[misc_regs_pkg::PC_LOCAL_DIS];
      port_ctrl.passthru_one_enable <= CFG_WDATA[misc_regs_pkg::PC_PT1_EN];
      port_ctrl.passthru_two_enable <= CFG_WDATA[misc_regs_pkg::PC_PT2_EN];
    end
  end

  assign LOCAL_CTRL_DISABLE = port_ctrl.local_ctrl_disable;
  assign PASSTHRU_ONE_ENABLE = port_ctrl.passthru_one_enable;
  assign PASSTHRU_TWO_ENABLE = port_ctrl.passthru_two_enable;

  // ==========================================================
  // Pin edge rate fields, driven straight to the pad controls
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PIN0_EDGE_RATE <= misc_regs_pkg::RST_PIN0;
      PIN1_EDGE_RATE <= misc_regs_pkg::RST_PIN1;
      PIN2_EDGE_RATE <= misc_regs_pkg::RST_PIN2;
    end else if (wr_slew_a) begin
      PIN0_EDGE_RATE <= CFG_WDATA[misc_regs_pkg::PIN0_LSB +: 2];
      PIN1_EDGE_RATE <= CFG_WDATA[misc_regs_pkg::PIN1_LSB +: 2];
      PIN2_EDGE_RATE <= CFG_WDATA[misc_regs_pkg::PIN2_LSB +: 2];
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PIN3_EDGE_RATE <= misc_regs_pkg::RST_PIN3;
      PIN4_EDGE_RATE <= misc_regs_pkg::RST_PIN4;
    end else if (wr_slew_b) begin
      PIN3_EDGE_RATE <= CFG_WDATA[misc_regs_pkg::PIN3_LSB +: 2];
      PIN4_EDGE_RATE <= CFG_WDATA[misc_regs_pkg::PIN4_LSB +: 2];
    end
  end

  // ==========================================================
  // Pipeline Z sync monitor
  sync_activity_detect u_sync_detect (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .line_sync_raw(LINE_SYNC_Z),
    .frame_sync_raw(FRAME_SYNC_Z),
    .pixel_valid_raw(PIXEL_VALID_Z),
    .status(sync_st)
  );

  // ==========================================================
  // Read path, unused and unmapped bits read zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (CFG_ADDR)
      misc_regs_pkg::ADDR_DEST_B: begin
        next_rdata[misc_regs_pkg::DEST_B_LSB +: 7] = ch2_translate_target_b;
      end
      misc_regs_pkg::ADDR_SYNC_Z: begin
        next_rdata[misc_regs_pkg::POS_PV_SEEN] = sync_st.pixel_valid_seen_z;
        next_rdata[misc_regs_pkg::POS_FS_SEEN] = sync_st.frame_sync_seen_z;
        next_rdata[misc_regs_pkg::POS_LS_SEEN] = sync_st.line_sync_seen_z;
        next_rdata[misc_regs_pkg::POS_FS_POL] = sync_st.frame_sync_polarity_z;
        next_rdata[misc_regs_pkg::POS_LS_POL] = sync_st.line_sync_polarity_z;
      end
      misc_regs_pkg::ADDR_KEY: begin
        next_rdata = write_key;
      end
      misc_regs_pkg::ADDR_PORT_CTRL: begin
        next_rdata[misc_regs_pkg::PC_LOCAL_DIS] = port_ctrl.local_ctrl_disable;
        next_rdata[misc_regs_pkg::PC_PT1_EN] = port_ctrl.passthru_one_enable;
        next_rdata[misc_regs_pkg::PC_PT2_EN] = port_ctrl.passthru_two_enable;
      end
      misc_regs_pkg::ADDR_SLEW_A: begin
        next_rdata[misc_regs_pkg::PIN0_LSB +: 2] = PIN0_EDGE_RATE;
        next_rdata[misc_regs_pkg::PIN1_LSB +: 2] = PIN1_EDGE_RATE;
        next_rdata[misc_regs_pkg::PIN2_LSB +: 2] = PIN2_EDGE_RATE;
      end
      misc_regs_pkg::ADDR_SLEW_B: begin
        next_rdata[misc_regs_pkg::PIN3_LSB +: 2] = PIN3_EDGE_RATE;
        next_rdata[misc_regs_pkg::PIN4_LSB +: 2] = PIN4_EDGE_RATE;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CFG_RDATA <= 8'h00;
      CFG_RVALID <= 1'b0;
    end else begin
      CFG_RVALID <= CFG_RD;
      if (CFG_RD) begin
        CFG_RDATA <= next_rdata;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n);

  property p_dest_b_write;
    wr_dest |=> ch2_translate_target_b == $past(CFG_WDATA[7:1]);
  endproperty
  a_dest_b_write: assert property (p_dest_b_write)
    else $error("destination B not stored from bits 7:1");

  property p_translate_hit;
    LINK_ADDR_VALID && (LINK_ADDR == CH2_TRANSLATE_MATCH_B)
      |=> REMOTE_ADDR_VALID && (REMOTE_ADDR == $past(ch2_translate_target_b));
  endproperty
  a_translate_hit: assert property (p_translate_hit)
    else $error("matching address not replaced by destination B");

  property p_translate_miss;
    LINK_ADDR_VALID && (LINK_ADDR != CH2_TRANSLATE_MATCH_B)
      |=> REMOTE_ADDR_VALID && (REMOTE_ADDR == $past(LINK_ADDR));
  endproperty
  a_translate_miss: assert property (p_translate_miss)
    else $error("non-matching address was altered");

  property p_sync_read;
    CFG_RD && (CFG_ADDR == misc_regs_pkg::ADDR_SYNC_Z)
      |=> CFG_RVALID && (CFG_RDATA[7] == 1'b0) && (CFG_RDATA[3:2] == 2'h0)
        && (CFG_RDATA[6] == $past(sync_st.pixel_valid_seen_z))
        && (CFG_RDATA[1] == $past(sync_st.frame_sync_polarity_z));
  endproperty
  a_sync_read: assert property (p_sync_read)
    else $error("sync status read layout wrong");

  property p_ctrl_unlocked;
    wr_ctrl && unlocked |=> port_ctrl == $past(CFG_WDATA[2:0]);
  endproperty
  a_ctrl_unlocked: assert property (p_ctrl_unlocked)
    else $error("unlocked port control write lost");

  property p_ctrl_locked;
    CFG_WR && (CFG_ADDR == misc_regs_pkg::ADDR_PORT_CTRL)
      && (write_key != 8'hbb) |=> $stable(port_ctrl);
  endproperty
  a_ctrl_locked: assert property (p_ctrl_locked)
    else $error("locked port control write took effect");

  property p_ctrl_readback;
    CFG_RD && (CFG_ADDR == misc_regs_pkg::ADDR_PORT_CTRL)
      |=> CFG_RVALID && (CFG_RDATA == {5'h00, $past(port_ctrl)});
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("port control readback wrong");

  property p_slew_a;
    wr_slew_a |=> (PIN0_EDGE_RATE == $past(CFG_WDATA[1:0]))
      && (PIN1_EDGE_RATE == $past(CFG_WDATA[3:2]))
      && (PIN2_EDGE_RATE == $past(CFG_WDATA[5:4]));
  endproperty
  a_slew_a: assert property (p_slew_a)
    else $error("first slew register fields misplaced");

  property p_slew_b;
    wr_slew_b |=> (PIN3_EDGE_RATE == $past(CFG_WDATA[3:2]))
      && (PIN4_EDGE_RATE == $past(CFG_WDATA[5:4]));
  endproperty
  a_slew_b: assert property (p_slew_b)
    else $error("second slew register fields misplaced");

  property p_slew_b_read;
    CFG_RD && (CFG_ADDR == misc_regs_pkg::ADDR_SLEW_B)
      |=> (CFG_RDATA[7:6] == 2'h0) && (CFG_RDATA[1:0] == 2'h0);
  endproperty
  a_slew_b_read: assert property (p_slew_b_read)
    else $error("unused slew bits read nonzero");

  property p_key_write;
    wr_key |=> write_key == $past(CFG_WDATA);
  endproperty
  a_key_write: assert property (p_key_write)
    else $error("unlock key not stored");

  property p_dest_b_read;
    CFG_RD && (CFG_ADDR == misc_regs_pkg::ADDR_DEST_B)
      |=> CFG_RVALID && (CFG_RDATA == {$past(ch2_translate_target_b), 1'b0});
  endproperty
  a_dest_b_read: assert property (p_dest_b_read)
    else $error("destination B readback wrong");

  property p_slew_a_read;
    CFG_RD && (CFG_ADDR == misc_regs_pkg::ADDR_SLEW_A)
      |=> (CFG_RDATA[7:6] == 2'h0) && (CFG_RDATA[1:0] == $past(PIN0_EDGE_RATE))
        && (CFG_RDATA[3:2] == $past(PIN1_EDGE_RATE));
  endproperty
  a_slew_a_read: assert property (p_slew_a_read)
    else $error("first slew register readback wrong");

  c_locked_attempt: cover property (wr_ctrl && !unlocked);
  c_unlocked_write: cover property (wr_ctrl && unlocked);
  c_translate_hit: cover property (LINK_ADDR_VALID && (LINK_ADDR == CH2_TRANSLATE_MATCH_B));
  c_sync_read: cover property (CFG_RD && (CFG_ADDR == misc_regs_pkg::ADDR_SYNC_Z));
endmodule

// [core/misc_regs_pkg.sv]
package misc_regs_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [15:0] ADDR_PORT_CTRL = 16'h0001;
  localparam logic [15:0] ADDR_DEST_B = 16'h0557;
  localparam logic [15:0] ADDR_SYNC_Z = 16'h055f;
  localparam logic [15:0] ADDR_KEY = 16'h056e;
  localparam logic [15:0] ADDR_SLEW_A = 16'h056f;
  localparam logic [15:0] ADDR_SLEW_B = 16'h0570;

  // ==========================================================
  // Reset values
  localparam logic [6:0] RST_DEST_B = 7'h00;
  localparam logic [7:0] RST_KEY = 8'hbb;
  localparam logic [7:0] UNLOCK_VALUE = 8'hbb;
  localparam logic [2:0] RST_PORT_CTRL = 3'h0;
  localparam logic [1:0] RST_PIN0 = 2'h2;
  localparam logic [1:0] RST_PIN1 = 2'h3;
  localparam logic [1:0] RST_PIN2 = 2'h3;
  localparam logic [1:0] RST_PIN3 = 2'h3;
  localparam logic [1:0] RST_PIN4 = 2'h3;

  // ==========================================================
  // Field positions
  localparam int DEST_B_LSB = 1;
  localparam int POS_PV_SEEN = 6;
  localparam int POS_FS_SEEN = 5;
  localparam int POS_LS_SEEN = 4;
  localparam int POS_FS_POL = 1;
  localparam int POS_LS_POL = 0;
  localparam int PIN0_LSB = 0;
  localparam int PIN1_LSB = 2;
  localparam int PIN2_LSB = 4;
  localparam int PIN3_LSB = 2;
  localparam int PIN4_LSB = 4;
  localparam int PC_LOCAL_DIS = 0;
  localparam int PC_PT1_EN = 1;
  localparam int PC_PT2_EN = 2;

  // ==========================================================
  // Timing: detection window is 2**WIN_CNT_W cycles
  localparam int WIN_CNT_W = 10;

  typedef struct packed {
    logic pixel_valid_seen_z;
    logic frame_sync_seen_z;
    logic line_sync_seen_z;
    logic frame_sync_polarity_z;
    logic line_sync_polarity_z;
  } sync_status_s;

  // Member order matches the register bits: bit 2 first, bit 0 last
  typedef struct packed {
    logic passthru_two_enable;
    logic passthru_one_enable;
    logic local_ctrl_disable;
  } port_ctrl_s;
endpackage

// [core/sync_activity_detect.sv]
`timescale 1ns/1ps
module sync_activity_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line_sync_raw,
  input wire logic frame_sync_raw,
  input wire logic pixel_valid_raw,
  output misc_regs_pkg::sync_status_s status
);
  localparam int W = misc_regs_pkg::WIN_CNT_W;

  logic [2:0] raw;
  logic [2:0] sy1;
  logic [2:0] sy2;
  logic [2:0] sy3;
  logic [2:0] lvl;
  logic [2:0] toggled;
  logic [2:0] change;
  logic [2:0] high_half;
  logic [W-1:0] win_cnt;
  logic win_end;
  logic [2:0] seen;
  logic [1:0] pol;

  assign raw = {pixel_valid_raw, frame_sync_raw, line_sync_raw};
  assign win_end = &win_cnt;

  // ==========================================================
  // Window counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt <= '0;
    end else begin
      win_cnt <= win_cnt + 1'b1;
    end
  end

  // ==========================================================
  // Per-signal synchroniser, activity and duty measurement
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_sig
      logic [W:0] high_cnt;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sy1[i] <= 1'b0;
          sy2[i] <= 1'b0;
          sy3[i] <= 1'b0;
          lvl[i] <= 1'b0;
          toggled[i] <= 1'b0;
          high_cnt <= '0;
          seen[i] <= 1'b0;
        end else begin
          sy1[i] <= raw[i];
          sy2[i] <= sy1[i];
          sy3[i] <= sy2[i];
          // A change counts once the last two stages agree
          if (sy2[i] == sy3[i]) begin
            lvl[i] <= sy3[i];
          end
          if (win_end) begin
            // A change on the closing cycle still counts for this window
            seen[i] <= toggled[i] | change[i];
            toggled[i] <= 1'b0;
            high_cnt <= '0;
          end else begin
            toggled[i] <= toggled[i] | change[i];
            high_cnt <= high_cnt + {{W{1'b0}}, lvl[i]};
          end
        end
      end
      // Signal mostly low means its pulses are active high
      assign high_half[i] = high_cnt[W-1];
      assign change[i] = (sy2[i] == sy3[i]) && (sy3[i] != lvl[i]);
    end
  endgenerate

  // ==========================================================
  // Polarity of the two sync signals, held while idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pol <= 2'h0;
    end else if (win_end) begin
      if (toggled[0] | change[0]) begin
        pol[0] <= ~high_half[0];
      end
      if (toggled[1] | change[1]) begin
        pol[1] <= ~high_half[1];
      end
    end
  end

  always_comb begin
    status.pixel_valid_seen_z = seen[2];
    status.frame_sync_seen_z = seen[1];
    status.line_sync_seen_z = seen[0];
    status.frame_sync_polarity_z = pol[1];
    status.line_sync_polarity_z = pol[0];
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_seen_only_at_window;
    !$stable(seen) |-> $past(win_end);
  endproperty
  a_seen_only_at_window: assert property (p_seen_only_at_window)
    else $error("activity flag changed outside window end");

  property p_idle_clears;
    win_end && !toggled[0] && !change[0] |=> !seen[0];
  endproperty
  a_idle_clears: assert property (p_idle_clears)
    else $error("line sync flag set without activity");

  c_line_active: cover property (win_end && toggled[0]);
endmodule

// [test/misc_ctrl_status_regs_tb.sv]
`timescale 1ns/1ps
module misc_ctrl_status_regs_tb;
  logic SYS_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic [15:0] CFG_ADDR = 16'h0000;
  logic CFG_WR = 1'b0;
  logic CFG_RD = 1'b0;
  logic [7:0] CFG_WDATA = 8'h00;
  logic [7:0] CFG_RDATA;
  logic CFG_RVALID;
  logic LINE_SYNC_Z = 1'b0;
  logic FRAME_SYNC_Z = 1'b0;
  logic PIXEL_VALID_Z = 1'b0;
  logic [6:0] CH2_TRANSLATE_MATCH_B = 7'h00;
  logic [6:0] LINK_ADDR = 7'h00;
  logic LINK_ADDR_VALID = 1'b0;
  logic [6:0] REMOTE_ADDR;
  logic REMOTE_ADDR_VALID;
  logic LOCAL_CTRL_DISABLE, PASSTHRU_ONE_ENABLE, PASSTHRU_TWO_ENABLE;
  logic [1:0] PIN0_EDGE_RATE, PIN1_EDGE_RATE, PIN2_EDGE_RATE, PIN3_EDGE_RATE, PIN4_EDGE_RATE;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int sc = 0;
  logic sync_en = 1'b0;
  logic [7:0] mdl [logic [15:0]];
  logic [15:0] regs [7] = '{misc_regs_pkg::ADDR_DEST_B, misc_regs_pkg::ADDR_SYNC_Z,
    misc_regs_pkg::ADDR_KEY, misc_regs_pkg::ADDR_SLEW_A, misc_regs_pkg::ADDR_SLEW_B,
    misc_regs_pkg::ADDR_PORT_CTRL, 16'h0558};

  misc_ctrl_status_regs uut (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .CFG_ADDR(CFG_ADDR),
    .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
    .CFG_RVALID(CFG_RVALID), .LINE_SYNC_Z(LINE_SYNC_Z), .FRAME_SYNC_Z(FRAME_SYNC_Z),
    .PIXEL_VALID_Z(PIXEL_VALID_Z), .CH2_TRANSLATE_MATCH_B(CH2_TRANSLATE_MATCH_B),
    .LINK_ADDR(LINK_ADDR), .LINK_ADDR_VALID(LINK_ADDR_VALID), .REMOTE_ADDR(REMOTE_ADDR),
    .REMOTE_ADDR_VALID(REMOTE_ADDR_VALID), .LOCAL_CTRL_DISABLE(LOCAL_CTRL_DISABLE),
    .PASSTHRU_ONE_ENABLE(PASSTHRU_ONE_ENABLE), .PASSTHRU_TWO_ENABLE(PASSTHRU_TWO_ENABLE),
    .PIN0_EDGE_RATE(PIN0_EDGE_RATE), .PIN1_EDGE_RATE(PIN1_EDGE_RATE),
    .PIN2_EDGE_RATE(PIN2_EDGE_RATE), .PIN3_EDGE_RATE(PIN3_EDGE_RATE),
    .PIN4_EDGE_RATE(PIN4_EDGE_RATE));

  // ==========================================================
  // Clock, timeout and video stimulus
  always #25 SYS_CLK = ~SYS_CLK;

  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      $display("Error timeout after %0d cycles", cycles);
      report_and_stop();
    end
  end

  // Line sync mostly low, frame sync mostly high, pixel valid square wave
  always @(posedge SYS_CLK) begin
    #1;
    if (sync_en) begin
      sc++;
      LINE_SYNC_Z = ((sc % 16) < 2);
      FRAME_SYNC_Z = ((sc % 64) >= 4);
      PIXEL_VALID_Z = ((sc % 8) < 4);
    end else if (sc != 0) begin
      // Park at idle levels so the closing window measures a clean duty
      LINE_SYNC_Z = 1'b0;
      FRAME_SYNC_Z = 1'b1;
      PIXEL_VALID_Z = 1'b0;
    end
  end

  // ==========================================================
  // Model and bus tasks
  function automatic void mdl_wr(input logic [15:0] a, input logic [7:0] d);
    case (a)
      misc_regs_pkg::ADDR_DEST_B: mdl[a] = d & 8'hfe;
      misc_regs_pkg::ADDR_KEY: mdl[a] = d;
      misc_regs_pkg::ADDR_SLEW_A: mdl[a] = d & 8'h3f;
      misc_regs_pkg::ADDR_SLEW_B: mdl[a] = d & 8'h3c;
      misc_regs_pkg::ADDR_PORT_CTRL: begin
        if (mdl[misc_regs_pkg::ADDR_KEY] == 8'hbb) begin
          mdl[a] = d & 8'h07;
        end
      end
      default: ;
    endcase
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    #1;
    CFG_ADDR = a;
    CFG_WDATA = d;
    CFG_WR = 1'b1;
    @(posedge SYS_CLK);
    #1;
    CFG_WR = 1'b0;
    mdl_wr(a, d);
  endtask

  task automatic rd(input logic [15:0] a);
    logic [7:0] e;
    e = mdl.exists(a) ? mdl[a] : 8'h00;
    @(posedge SYS_CLK);
    #1;
    CFG_ADDR = a;
    CFG_RD = 1'b1;
    @(posedge SYS_CLK);
    #1;
    CFG_RD = 1'b0;
    chk($sformatf("rvalid %h", a), 8'h01, {7'h00, CFG_RVALID});
    chk($sformatf("rdata %h", a), e, CFG_RDATA);
  endtask

  task automatic chk_outs();
    chk("pins a", {2'h0, mdl[misc_regs_pkg::ADDR_SLEW_A][5:0]},
        {2'h0, PIN2_EDGE_RATE, PIN1_EDGE_RATE, PIN0_EDGE_RATE});
    chk("pins b", {4'h0, mdl[misc_regs_pkg::ADDR_SLEW_B][5:2]},
        {4'h0, PIN4_EDGE_RATE, PIN3_EDGE_RATE});
    chk("port ctrl", {5'h00, mdl[misc_regs_pkg::ADDR_PORT_CTRL][2:0]},
        {5'h00, PASSTHRU_TWO_ENABLE, PASSTHRU_ONE_ENABLE, LOCAL_CTRL_DISABLE});
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] keys [4] = '{8'hba, 8'hbb, 8'hbc, 8'h00};
    logic [6:0] q [$];
    logic [6:0] e;
    int seed;
    seed = $urandom(58);
    repeat (2) @(posedge SYS_CLK);
    #1;
    ARST_N = 1'b1;
    repeat (3) @(posedge SYS_CLK);
    #1;
    mdl[misc_regs_pkg::ADDR_DEST_B] = 8'h00;
    mdl[misc_regs_pkg::ADDR_SYNC_Z] = 8'h00;
    mdl[misc_regs_pkg::ADDR_KEY] = 8'hbb;
    mdl[misc_regs_pkg::ADDR_SLEW_A] = 8'h3e;
    mdl[misc_regs_pkg::ADDR_SLEW_B] = 8'h3c;
    mdl[misc_regs_pkg::ADDR_PORT_CTRL] = 8'h00;
    chk_outs();
    for (int i = 0; i < 7; i++) begin
      rd(regs[i]);
    end
    $display("test reset done");

    for (int k = 0; k < 4; k++) begin
      wr(misc_regs_pkg::ADDR_SLEW_A, {2'h3, 2'(k), 2'(k), 2'(k)});
      wr(misc_regs_pkg::ADDR_SLEW_B, {2'h3, 2'(k), 2'(k), 2'(k)});
      chk_outs();
    end
    for (int i = 0; i < 24; i++) begin
      wr(regs[i % 7], 8'($urandom));
      rd(regs[i % 7]);
      chk_outs();
    end
    $display("test register access done");

    for (int i = 0; i < 8; i++) begin
      wr(misc_regs_pkg::ADDR_KEY, keys[i % 4]);
      wr(misc_regs_pkg::ADDR_PORT_CTRL, 8'($urandom) ^ 8'(i));
      chk_outs();
      rd(misc_regs_pkg::ADDR_PORT_CTRL);
      rd(misc_regs_pkg::ADDR_KEY);
    end
    $display("test write gate done");

    wr(misc_regs_pkg::ADDR_DEST_B, 8'($urandom));
    CH2_TRANSLATE_MATCH_B = 7'($urandom);
    q = '{CH2_TRANSLATE_MATCH_B, CH2_TRANSLATE_MATCH_B ^ 7'h01, CH2_TRANSLATE_MATCH_B,
          7'($urandom), CH2_TRANSLATE_MATCH_B ^ 7'h40, CH2_TRANSLATE_MATCH_B};
    @(posedge SYS_CLK);
    #1;
    foreach (q[i]) begin
      LINK_ADDR_VALID = 1'b1;
      LINK_ADDR = q[i];
      e = (q[i] == CH2_TRANSLATE_MATCH_B) ? mdl[misc_regs_pkg::ADDR_DEST_B][7:1] : q[i];
      @(posedge SYS_CLK);
      #1;
      chk("remote valid", 8'h01, {7'h00, REMOTE_ADDR_VALID});
      chk("remote addr", {1'b0, e}, {1'b0, REMOTE_ADDR});
    end
    LINK_ADDR_VALID = 1'b0;
    @(posedge SYS_CLK);
    #1;
    chk("remote idle", 8'h00, {7'h00, REMOTE_ADDR_VALID});
    $display("test translation done");

    sync_en = 1'b1;
    repeat (2052) @(posedge SYS_CLK);
    mdl[misc_regs_pkg::ADDR_SYNC_Z] = 8'h71;
    rd(misc_regs_pkg::ADDR_SYNC_Z);
    sync_en = 1'b0;
    repeat (2052) @(posedge SYS_CLK);
    mdl[misc_regs_pkg::ADDR_SYNC_Z] = 8'h01;
    rd(misc_regs_pkg::ADDR_SYNC_Z);
    $display("test sync detect done");
    report_and_stop();
  end
endmodule
